// File: alu_core.sv
// Notes on behaviour
// - add_imm_to_pair adds a constant to a 16-bit pair; Z,C,N,V,S; two cycles.
// - register subtract writes destination minus source; all six flags; one cycle.
// - sub_imm_with_borrow subtracts constant and carry; all six flags; one cycle.
// - sub_imm_from_pair subtracts a constant from a pair; Z,C,N,V,S; two cycles.
// - and_with_imm ANDs constant into destination; Z,N,V,S; one cycle.
// - or_with_imm ORs constant into destination; Z,N,V,S; one cycle.
// - set_mask_bits ORs mask into destination; Z,N,V,S; one cycle.
// - clear_mask_bits ANDs destination with inverted mask; Z,N,V,S; one cycle.
module alu_core
  import alu_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // request from the decoder
  input wire logic start,
  input wire alu_op_type op,
  input wire logic [7:0] dst_val,
  input wire logic [7:0] source_register,
  input wire logic [7:0] imm_val,
  input wire logic [15:0] pair_val,
  input wire logic [5:0] sreg_in,
  // answer to the register file
  output logic busy,
  output logic done,
  output logic [15:0] result,
  output logic is_word,
  output logic [5:0] sreg_out
);

  typedef enum logic [1:0] {ST_IDLE, ST_WORD, ST_DONE} alu_state_type;

  typedef struct packed {
    alu_state_type st;
    logic [15:0] result;
    logic [5:0] sreg;
    logic is_word;
    logic done;
  } alu_regs_type;

  alu_regs_type cur_ff;
  alu_regs_type nxt_cur;
  logic [7:0] opd_b;
  logic [15:0] wres_ff;
  logic [5:0] wflags_ff;
  logic [15:0] nxt_wres;
  logic [5:0] nxt_wflags;

  alu_res_if res ();

  // ********************************
  // operand selection
  // ********************************
  // immediate forms take the constant, register forms the source
  always_comb begin
    unique case (op)
      ALU_OP_SUB_IMM, ALU_OP_SUB_IMM_WITH_BORROW, ALU_OP_AND_WITH_IMM,
      ALU_OP_OR_WITH_IMM, ALU_OP_SET_MASK_BITS, ALU_OP_CLEAR_MASK_BITS: opd_b = imm_val;
      default: opd_b = source_register;
    endcase
  end

  alu_calc u_calc (
    .op(op),
    .opd_a(dst_val),
    .opd_b(opd_b),
    .pair(pair_val),
    .imm6(imm_val[5:0]),
    .carry_in(sreg_in[ALU_FLAG_C]),
    .res(res)
  );

  // ********************************
  // sequencing
  // ********************************
  // word ops hold their result one extra cycle to give the two-cycle timing
  always_comb begin
    nxt_cur = cur_ff;
    nxt_cur.done = 1'b0;
    nxt_wres = wres_ff;
    nxt_wflags = wflags_ff;
    unique case (cur_ff.st)
      ST_IDLE, ST_DONE: begin
        nxt_cur.st = ST_IDLE;
        if (start) begin
          if (res.is_word) begin
            nxt_cur.st = ST_WORD;
            nxt_wres = res.result;
            nxt_wflags = (sreg_in & ~res.flag_mask) | (res.flags & res.flag_mask);
          end else begin
            nxt_cur.done = 1'b1;
            nxt_cur.result = res.result;
            nxt_cur.is_word = 1'b0;
            nxt_cur.sreg = (sreg_in & ~res.flag_mask) | (res.flags & res.flag_mask);
          end
        end
      end
      ST_WORD: begin
        nxt_cur.st = ST_DONE;
        nxt_cur.done = 1'b1;
        nxt_cur.result = wres_ff;
        nxt_cur.is_word = 1'b1;
        nxt_cur.sreg = wflags_ff;
      end
      default: nxt_cur.st = ST_IDLE;
    endcase
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      cur_ff <= '{st: ST_IDLE, result: 16'h0000, sreg: 6'h00, is_word: 1'b0, done: 1'b0};
      wres_ff <= 16'h0000;
      wflags_ff <= 6'h00;
    end else begin
      cur_ff <= nxt_cur;
      wres_ff <= nxt_wres;
      wflags_ff <= nxt_wflags;
    end
  end

  // ********************************
  // outputs
  // ********************************
  assign busy = (cur_ff.st == ST_WORD);
  assign done = cur_ff.done;
  assign result = cur_ff.result;
  assign is_word = cur_ff.is_word;
  assign sreg_out = cur_ff.sreg;

  // ********************************
  // checks
  // ********************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  // timing of the answer
  a_single_cycle_done: assert property ((start && !busy && !res.is_word) |=> done)
    else $error("single-cycle op did not finish in one cycle");
  a_word_two_cycle: assert property ((start && !busy && res.is_word) |=> !done ##1 done)
    else $error("word op did not finish in two cycles");
  // busy marks only the middle cycle, so a poke there is dropped
  a_word_busy_mid: assert property ((start && !busy && res.is_word) |=> busy ##1 !busy)
    else $error("busy not shown in the middle cycle");
  a_busy_then_done: assert property (busy |=> done && !busy)
    else $error("busy cycle not followed by done");
  a_byte_upper_zero: assert property ((start && !busy && !res.is_word)
    |=> result[15:8] == 8'h00 && !is_word)
    else $error("byte result upper half not zero");

  // pair results
  a_word_add_sum: assert property ((start && !busy && op == ALU_OP_ADD_IMM_TO_PAIR)
    |=> ##1 result == $past(pair_val, 2) + {10'h000, $past(imm_val[5:0], 2)} && is_word)
    else $error("pair sum wrong");
  a_word_sub_diff: assert property ((start && !busy && op == ALU_OP_SUB_IMM_FROM_PAIR)
    |=> ##1 result == $past(pair_val, 2) - {10'h000, $past(imm_val[5:0], 2)})
    else $error("pair difference wrong");
  a_word_sub_borrow: assert property ((start && !busy && op == ALU_OP_SUB_IMM_FROM_PAIR)
    |=> ##1 sreg_out[ALU_FLAG_C] == ($past(pair_val, 2) < {10'h000, $past(imm_val[5:0], 2)}))
    else $error("pair borrow wrong");

  // byte arithmetic
  a_sub_result: assert property ((start && !busy && op == ALU_OP_SUB)
    |=> result[7:0] == $past(dst_val) - $past(source_register))
    else $error("subtract result wrong");
  a_sub_borrow_flag: assert property ((start && !busy && op == ALU_OP_SUB)
    |=> sreg_out[ALU_FLAG_C] == ($past(dst_val) < $past(source_register)))
    else $error("subtract borrow wrong");
  a_sub_imm_with_borrow_result: assert property ((start && !busy && op == ALU_OP_SUB_IMM_WITH_BORROW)
    |=> result[7:0] == $past(dst_val) - $past(imm_val) - {7'h00, $past(sreg_in[ALU_FLAG_C])})
    else $error("borrow subtract result wrong");
  a_neg_result: assert property ((start && !busy && op == ALU_OP_TWOS_COMPLEMENT)
    |=> result[7:0] == 8'h00 - $past(dst_val))
    else $error("twos complement wrong");

  // logic results
  a_and_imm_res: assert property ((start && !busy && op == ALU_OP_AND_WITH_IMM)
    |=> result[7:0] == ($past(dst_val) & $past(imm_val)) && !sreg_out[ALU_FLAG_V])
    else $error("and immediate wrong");
  a_or_imm_res: assert property ((start && !busy && op == ALU_OP_OR_WITH_IMM)
    |=> result[7:0] == ($past(dst_val) | $past(imm_val)))
    else $error("or immediate wrong");
  a_set_bits_res: assert property ((start && !busy && op == ALU_OP_SET_MASK_BITS)
    |=> (result[7:0] & $past(imm_val)) == $past(imm_val))
    else $error("mask bits not set");
  a_clear_bits_res: assert property ((start && !busy && op == ALU_OP_CLEAR_MASK_BITS)
    |=> (result[7:0] & $past(imm_val)) == 8'h00)
    else $error("mask bits not cleared");
  a_xor_result: assert property ((start && !busy && op == ALU_OP_REG_XOR)
    |=> result[7:0] == ($past(dst_val) ^ $past(source_register)))
    else $error("exclusive or wrong");
  // logic ops clear overflow, so sign follows negative
  a_logic_sign_flag: assert property ((start && !busy && op inside {ALU_OP_AND, ALU_OP_OR,
    ALU_OP_REG_XOR, ALU_OP_CLEAR_MASK_BITS}) |=> sreg_out[ALU_FLAG_S] == sreg_out[ALU_FLAG_N])
    else $error("logic sign flag wrong");
  a_com_carry_set: assert property ((start && !busy && op == ALU_OP_ONES_COMPLEMENT)
    |=> sreg_out[ALU_FLAG_C] && sreg_out[ALU_FLAG_H] == $past(sreg_in[ALU_FLAG_H]))
    else $error("ones complement flags wrong");

  // main scenarios
  c_word_add: cover property (start && op == ALU_OP_ADD_IMM_TO_PAIR ##2 done);
  c_sub_borrow: cover property (start && op == ALU_OP_REG_SUB_WITH_BORROW ##1 sreg_out[0]);
  c_neg_zero: cover property (start && op == ALU_OP_TWOS_COMPLEMENT ##1 sreg_out[1]);
  c_poke_busy: cover property (busy && start);
  c_byte_after_word: cover property (done && is_word && start && !res.is_word);

endmodule

// File: alu_pkg.sv
package alu_pkg;

  // ********************************
  // operation codes
  // ********************************
  typedef enum logic [4:0] {
    ALU_OP_ADD,
    ALU_OP_ADC,
    ALU_OP_SUB,
    ALU_OP_SUB_IMM,
    ALU_OP_REG_SUB_WITH_BORROW,
    ALU_OP_SUB_IMM_WITH_BORROW,
    ALU_OP_AND,
    ALU_OP_AND_WITH_IMM,
    ALU_OP_OR,
    ALU_OP_OR_WITH_IMM,
    ALU_OP_REG_XOR,
    ALU_OP_SET_MASK_BITS,
    ALU_OP_CLEAR_MASK_BITS,
    ALU_OP_ONES_COMPLEMENT,
    ALU_OP_TWOS_COMPLEMENT,
    ALU_OP_ADD_IMM_TO_PAIR,
    ALU_OP_SUB_IMM_FROM_PAIR
  } alu_op_type;

  // ********************************
  // status flag positions
  // ********************************
  localparam int ALU_FLAG_C = 0;
  localparam int ALU_FLAG_Z = 1;
  localparam int ALU_FLAG_N = 2;
  localparam int ALU_FLAG_V = 3;
  localparam int ALU_FLAG_S = 4;
  localparam int ALU_FLAG_H = 5;
  localparam int ALU_NFLAGS = 6;

  // ********************************
  // flag masks and constants
  // ********************************
  localparam logic [5:0] ALU_MASK_ARITH = 6'h3F;
  localparam logic [5:0] ALU_MASK_WORD = 6'h1F;
  localparam logic [5:0] ALU_MASK_LOGIC = 6'h1E;
  localparam logic [5:0] ALU_MASK_NONE = 6'h00;
  localparam logic [7:0] ALU_ALL_ONES = 8'hFF;
  localparam logic [1:0] ALU_CYC_SINGLE = 2'h1;
  localparam logic [1:0] ALU_CYC_WORD = 2'h2;

endpackage

// File: alu_res_if.sv
interface alu_res_if;
  import alu_pkg::*;
  logic [15:0] result;
  logic [5:0] flags;
  logic [5:0] flag_mask;
  logic is_word;

  modport core (output result, output flags, output flag_mask, output is_word);
  modport user (input result, input flags, input flag_mask, input is_word);
endinterface

// File: alu_calc.sv
module alu_calc
  import alu_pkg::*;
(
  // operation and operands
  input wire alu_op_type op,
  input wire logic [7:0] opd_a,
  input wire logic [7:0] opd_b,
  input wire logic [15:0] pair,
  input wire logic [5:0] imm6,
  input wire logic carry_in,
  // combinational result
  alu_res_if.core res
);

  // ********************************
  // shared arithmetic helpers
  // ********************************
  // 8-bit add or subtract with all six flags
  function automatic logic [13:0] add8(input logic [7:0] a, input logic [7:0] b,
                                       input logic ci, input logic sub);
    logic [8:0] s;
    logic [4:0] lo;
    logic [7:0] bb;
    logic [5:0] f;
    bb = sub ? ~b : b;
    s = {1'b0, a} + {1'b0, bb} + {8'h00, (sub ? ~ci : ci)};
    lo = {1'b0, a[3:0]} + {1'b0, bb[3:0]} + {4'h0, (sub ? ~ci : ci)};
    f = '0;
    f[ALU_FLAG_C] = sub ? ~s[8] : s[8];
    f[ALU_FLAG_H] = sub ? ~lo[4] : lo[4];
    f[ALU_FLAG_N] = s[7];
    f[ALU_FLAG_Z] = (s[7:0] == 8'h00);
    f[ALU_FLAG_V] = (a[7] == bb[7]) && (s[7] != a[7]);
    f[ALU_FLAG_S] = f[ALU_FLAG_N] ^ f[ALU_FLAG_V];
    return {f, s[7:0]};
  endfunction

  // logic result flags: overflow cleared
  function automatic logic [13:0] logic8(input logic [7:0] r);
    logic [5:0] f;
    f = '0;
    f[ALU_FLAG_N] = r[7];
    f[ALU_FLAG_Z] = (r == 8'h00);
    f[ALU_FLAG_S] = r[7];
    return {f, r};
  endfunction

  logic [13:0] t;
  logic [16:0] w;

  // ********************************
  // result selection
  // ********************************
  always_comb begin
    t = '0;
    w = '0;
    res.flag_mask = ALU_MASK_ARITH;
    res.is_word = 1'b0;
    unique case (op)
      ALU_OP_ADD: t = add8(opd_a, opd_b, 1'b0, 1'b0);
      ALU_OP_ADC: t = add8(opd_a, opd_b, carry_in, 1'b0);
      ALU_OP_SUB: t = add8(opd_a, opd_b, 1'b0, 1'b1);
      ALU_OP_SUB_IMM: t = add8(opd_a, opd_b, 1'b0, 1'b1);
      ALU_OP_REG_SUB_WITH_BORROW: t = add8(opd_a, opd_b, carry_in, 1'b1);
      ALU_OP_SUB_IMM_WITH_BORROW: t = add8(opd_a, opd_b, carry_in, 1'b1);
      ALU_OP_TWOS_COMPLEMENT: t = add8(8'h00, opd_a, 1'b0, 1'b1);
      ALU_OP_AND, ALU_OP_AND_WITH_IMM: begin
        t = logic8(opd_a & opd_b);
        res.flag_mask = ALU_MASK_LOGIC;
      end
      ALU_OP_OR, ALU_OP_OR_WITH_IMM, ALU_OP_SET_MASK_BITS: begin
        t = logic8(opd_a | opd_b);
        res.flag_mask = ALU_MASK_LOGIC;
      end
      ALU_OP_REG_XOR: begin
        t = logic8(opd_a ^ opd_b);
        res.flag_mask = ALU_MASK_LOGIC;
      end
      ALU_OP_CLEAR_MASK_BITS: begin
        t = logic8(opd_a & (ALU_ALL_ONES - opd_b));
        res.flag_mask = ALU_MASK_LOGIC;
      end
      ALU_OP_ONES_COMPLEMENT: begin
        t = logic8(ALU_ALL_ONES - opd_a);
        t[8 + ALU_FLAG_C] = 1'b1;
        res.flag_mask = ALU_MASK_WORD;
      end
      ALU_OP_ADD_IMM_TO_PAIR, ALU_OP_SUB_IMM_FROM_PAIR: begin
        res.is_word = 1'b1;
        res.flag_mask = ALU_MASK_WORD;
        if (op == ALU_OP_ADD_IMM_TO_PAIR) begin
          w = {1'b0, pair} + {11'h000, imm6};
        end else begin
          w = {1'b0, pair} - {11'h000, imm6};
        end
      end
      default: res.flag_mask = ALU_MASK_NONE;
    endcase
  end

  // ********************************
  // word flags and outputs
  // ********************************
  always_comb begin
    res.result = {8'h00, t[7:0]};
    res.flags = t[13:8];
    if (res.is_word) begin
      res.result = w[15:0];
      res.flags = '0;
      res.flags[ALU_FLAG_Z] = (w[15:0] == 16'h0000);
      res.flags[ALU_FLAG_N] = w[15];
      res.flags[ALU_FLAG_C] = w[16];
      // overflow: sign of the pair flips the wrong way
      res.flags[ALU_FLAG_V] = (op == ALU_OP_ADD_IMM_TO_PAIR) ? (~pair[15] & w[15])
                                                             : (pair[15] & ~w[15]);
      res.flags[ALU_FLAG_S] = res.flags[ALU_FLAG_N] ^ res.flags[ALU_FLAG_V];
    end
  end

endmodule

// File: alu_dec_model.sv
module alu_dec_model
  import alu_pkg::*;
(
  // clock and state of the datapath
  input wire logic mclk,
  input wire logic busy,
  // request towards the datapath
  output logic start,
  output alu_op_type op,
  output logic [7:0] dst_val,
  output logic [7:0] source_register,
  output logic [7:0] imm_val,
  output logic [15:0] pair_val,
  output logic [5:0] sreg_in
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    start = 1'b0;
    op = ALU_OP_ADD;
    {dst_val, source_register, imm_val, pair_val, sreg_in} = '0;
  end

  // ********************************
  // requests, always changed at the falling edge
  // ********************************
  task automatic issue(input alu_op_type o, input logic [45:0] v, input logic poke);
    start = 1'b1;
    op = o;
    {dst_val, source_register, imm_val, pair_val, sreg_in} = v;
    @(negedge mclk);
    // busy cycle: operands were taken, so show junk; poke asks during busy
    if ((o == ALU_OP_ADD_IMM_TO_PAIR) || (o == ALU_OP_SUB_IMM_FROM_PAIR)) begin
      start = poke;
      {dst_val, source_register, imm_val, pair_val, sreg_in} = ~v;
      @(negedge mclk);
    end
  endtask

  // released lines show the inverse, not a stale value
  task automatic idle();
    start = 1'b0;
    {dst_val, source_register, imm_val, pair_val, sreg_in} =
      ~{dst_val, source_register, imm_val, pair_val, sreg_in};
    @(negedge mclk);
  endtask
endmodule

// File: arith_logic_unit_bench.sv
module arith_logic_unit_bench;
  import alu_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct packed {logic w; logic [15:0] r; logic [5:0] f; int unsigned at;} alu_note_type;

  logic mclk, sys_rst, start, busy, done, is_word;
  alu_op_type op;
  logic [7:0] dst_val, source_register, imm_val;
  logic [15:0] pair_val, result;
  logic [5:0] sreg_in, sreg_out;
  int err_total = 0;
  int compares = 0;
  int unsigned cyc = 0;
  integer seed;
  logic prev_busy = 1'b0;
  alu_note_type notes[$];

  alu_core DUT (.mclk, .sys_rst, .start, .op, .dst_val, .source_register, .imm_val,
    .pair_val, .sreg_in, .busy, .done, .result, .is_word, .sreg_out);
  alu_dec_model dec (.mclk, .busy, .start, .op, .dst_val, .source_register, .imm_val,
    .pair_val, .sreg_in);

  // clock and cycle count
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  always @(posedge mclk) cyc <= cyc + 1;

  // ********************************
  // expected results
  // ********************************
  function automatic alu_note_type expect_of(input alu_op_type o, input logic [45:0] v);
    logic [7:0] a, b, k, x, y;
    logic [15:0] p;
    logic [5:0] s, f;
    logic [16:0] r;
    logic sub, ci, ar;
    alu_note_type e;
    {a, b, k, p, s} = v;
    f = s;
    {sub, ci, ar, x, y} = {3'b001, a, b};
    case (o)
      ALU_OP_ADC: ci = s[ALU_FLAG_C];
      ALU_OP_SUB: sub = 1'b1;
      ALU_OP_SUB_IMM: {sub, y} = {1'b1, k};
      ALU_OP_REG_SUB_WITH_BORROW: {sub, ci} = {1'b1, s[ALU_FLAG_C]};
      ALU_OP_SUB_IMM_WITH_BORROW: {sub, ci, y} = {1'b1, s[ALU_FLAG_C], k};
      ALU_OP_TWOS_COMPLEMENT: {sub, x, y} = {1'b1, 8'h00, a};
      ALU_OP_AND: {ar, y} = {1'b0, a & b};
      ALU_OP_AND_WITH_IMM: {ar, y} = {1'b0, a & k};
      ALU_OP_OR: {ar, y} = {1'b0, a | b};
      ALU_OP_OR_WITH_IMM, ALU_OP_SET_MASK_BITS: {ar, y} = {1'b0, a | k};
      ALU_OP_REG_XOR: {ar, y} = {1'b0, a ^ b};
      ALU_OP_CLEAR_MASK_BITS: {ar, y} = {1'b0, a & ~k};
      ALU_OP_ONES_COMPLEMENT: {ar, y, f[ALU_FLAG_C]} = {1'b0, ~a, 1'b1};
      default: ;
    endcase
    e.w = (o == ALU_OP_ADD_IMM_TO_PAIR) || (o == ALU_OP_SUB_IMM_FROM_PAIR);
    if (e.w) begin
      sub = (o == ALU_OP_SUB_IMM_FROM_PAIR);
      r = sub ? {1'b0, p} - {11'h000, k[5:0]} : {1'b0, p} + {11'h000, k[5:0]};
      f[ALU_FLAG_C] = r[16];
      f[ALU_FLAG_V] = sub ? (p[15] & ~r[15]) : (~p[15] & r[15]);
      {f[ALU_FLAG_N], f[ALU_FLAG_Z]} = {r[15], r[15:0] == 16'h0000};
    end else begin
      r = sub ? {9'h000, x} - {9'h000, y} - 17'(ci) : {9'h000, x} + {9'h000, y} + 17'(ci);
      if (!ar) r = {9'h000, y};
      // carry into a bit is x ^ y ^ r there, for add and subtract alike
      if (ar) begin
        f[ALU_FLAG_C] = r[8];
        f[ALU_FLAG_H] = x[4] ^ y[4] ^ r[4];
        f[ALU_FLAG_V] = (x[7] ^ r[7]) & ~(sub ^ x[7] ^ y[7]);
      end else f[ALU_FLAG_V] = 1'b0;
      r[16:8] = 9'h000;
      {f[ALU_FLAG_N], f[ALU_FLAG_Z]} = {r[7], r[7:0] == 8'h00};
    end
    f[ALU_FLAG_S] = f[ALU_FLAG_N] ^ f[ALU_FLAG_V];
    {e.r, e.f, e.at} = {r[15:0], f, 32'h0};
    return e;
  endfunction

  // ********************************
  // driving, noting and comparing
  // ********************************
  task automatic drive(input alu_op_type o, input logic [45:0] v, input logic poke);
    alu_note_type e;
    e = expect_of(o, v);
    e.at = cyc + (e.w ? 2 : 1);
    notes.push_back(e);
    dec.issue(o, v, poke);
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t %s got %0h expected %0h", $time, what, got, exp);
    end
  endtask

  task automatic check_flags(input logic [5:0] got, input logic [5:0] exp);
    check(32'(got), 32'(exp), "flags");
  endtask

  task automatic finish_test();
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // watcher: each done takes the oldest note; an extra done has none
  always @(negedge mclk) begin
    alu_note_type n;
    if (done === 1'b1) begin
      if (notes.size() == 0) check(32'h1, 32'h0, "done without request");
      else begin
        n = notes.pop_front();
        check(cyc, n.at, "latency");
        check(32'({is_word, result}), 32'({n.w, n.r}), "result");
        check_flags(sreg_out, n.f);
        check(32'({prev_busy, busy}), 32'({n.w, 1'b0}), "busy");
      end
    end
    prev_busy = busy;
  end

  // ********************************
  // main sequence
  // ********************************
  initial begin
    alu_op_type o;
    logic [45:0] v;
    seed = 60084;
    sys_rst = 1'b1;
    repeat (10) @(posedge mclk);
    @(negedge mclk);
    check(32'({busy, done, is_word, result, sreg_out}), 32'h0, "reset state");
    sys_rst = 1'b0;
    // boundaries of carry, borrow and overflow, back to back
    drive(ALU_OP_ADD, {8'hFF, 8'h01, 8'h00, 16'h0000, 6'h00}, 1'b0);
    drive(ALU_OP_SUB, {8'h00, 8'h01, 8'h00, 16'h0000, 6'h00}, 1'b0);
    drive(ALU_OP_SUB_IMM_WITH_BORROW, {8'h00, 8'h00, 8'h00, 16'h0000, 6'h01}, 1'b0);
    drive(ALU_OP_TWOS_COMPLEMENT, {8'h80, 8'h00, 8'h00, 16'h0000, 6'h00}, 1'b0);
    drive(ALU_OP_CLEAR_MASK_BITS, {8'hFF, 8'h00, 8'hFF, 16'h0000, 6'h3F}, 1'b0);
    drive(ALU_OP_ADD_IMM_TO_PAIR, {8'h00, 8'h00, 8'h3F, 16'hFFFF, 6'h20}, 1'b1);
    drive(ALU_OP_SUB_IMM_FROM_PAIR, {8'h00, 8'h00, 8'h01, 16'h8000, 6'h00}, 1'b0);
    $display("test boundaries done");
    // every operation in turn, random operands, busy cycles poked on odd i only
    for (int i = 0; i < 340; i++) begin
      o = alu_op_type'(i % 17);
      v = 46'({$random(seed), $random(seed)});
      if (o == ALU_OP_ADD_IMM_TO_PAIR || o == ALU_OP_SUB_IMM_FROM_PAIR) v[29:28] = 2'b00;
      drive(o, v, i[0]);
    end
    dec.idle();
    for (int i = 0; i < 20 && notes.size() > 0; i++) @(negedge mclk);
    check(32'(notes.size()), 32'h0, "missing done");
    $display("test random sweep done");
    finish_test();
  end
endmodule
